//--- core/srt_timer.v
// Slow-clock real-time timer with an AXI4-Lite register slave.
// Assumes slow_clk_i and cal_tick_i are asynchronous pins far slower than aclk.
`include "srt_consts.vh"
`default_nettype none

module srt_timer
(
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        slow_clk_i,
    input  wire        cal_tick_i,
    input  wire [3:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         irq_o,
    output reg         alarm_o
);

    // ------------------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------------------
    reg  [2:0]  slow_sync_r;
    reg  [2:0]  cal_sync_r;
    wire        slow_tick;
    wire        cal_tick;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            slow_sync_r <= 3'h0;
            cal_sync_r  <= 3'h0;
        end
        else
        begin
            slow_sync_r <= {slow_sync_r[1:0], slow_clk_i};
            cal_sync_r  <= {cal_sync_r[1:0], cal_tick_i};
        end
    end

    // Edge detectors look only at the second and third stages
    assign slow_tick = slow_sync_r[1] & ~slow_sync_r[2];
    assign cal_tick  = cal_sync_r[1] & ~cal_sync_r[2];

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    reg  [15:0] divisor_r;
    reg         alm_ien_r;
    reg         wrap_ien_r;
    reg         disable_r;
    reg         cal_sel_r;
    reg  [31:0] alarm_r;
    reg  [15:0] presc_r;
    reg  [31:0] count_r;
    reg         wrap_flag_r;
    reg         alm_flag_r;
    reg         irq_d1_r;
    reg         irq_d2_r;

    // Write channel holding state
    reg         aw_hold_r;
    reg  [3:0]  awaddr_r;
    reg         w_hold_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;

    wire        aw_fire   = s_axi_awvalid & s_axi_awready;
    wire        w_fire    = s_axi_wvalid & s_axi_wready;
    wire        ar_fire   = s_axi_arvalid & s_axi_arready;
    wire        wr_do     = aw_hold_r & w_hold_r & ~s_axi_bvalid;
    wire        wr_mode   = wr_do & ({awaddr_r[3:2], 2'h0} == `SRT_OFS_MODE);
    wire        wr_alarm  = wr_do & ({awaddr_r[3:2], 2'h0} == `SRT_OFS_ALARM);
    wire        wr_ok     = wr_mode | wr_alarm;
    wire        restart   = wr_mode & wstrb_r[2] & wdata_r[`SRT_MODE_RESTART];
    wire        stat_read = ar_fire & ({s_axi_araddr[3:2], 2'h0} == `SRT_OFS_STATUS);

    // ------------------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------------------
    wire        run       = ~disable_r & slow_tick;
    wire        presc_end = (presc_r >= divisor_r - 16'h0001);
    wire        wrap_ev   = run & presc_end;
    wire        cnt_ev    = ~disable_r & (cal_sel_r ? cal_tick : wrap_ev);
    wire        match     = ~disable_r & (count_r == alarm_r);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            presc_r <= 16'h0000;
            count_r <= 32'h00000000;
        end
        else if (restart)
        begin
            presc_r <= 16'h0000;
            count_r <= 32'h00000000;
        end
        else
        begin
            if (run)
                presc_r <= presc_end ? 16'h0000 : presc_r + 16'h0001;
            if (cnt_ev)
                count_r <= count_r + 32'h00000001;
        end
    end

    // ------------------------------------------------------------------------
    // Alarm value byte lanes
    // ------------------------------------------------------------------------
    wire [31:0] alarm_nxt;
    genvar      lane;

    generate
        for (lane = 0; lane < 4; lane = lane + 1)
        begin : g_alarm_lane
            assign alarm_nxt[lane*8 +: 8] = (wr_alarm & wstrb_r[lane]) ? wdata_r[lane*8 +: 8]
                                                                       : alarm_r[lane*8 +: 8];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Mode and alarm registers
    // ------------------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            divisor_r  <= `SRT_DIV_RESET;
            alm_ien_r  <= 1'b0;
            wrap_ien_r <= 1'b0;
            disable_r  <= 1'b0;
            cal_sel_r  <= 1'b0;
            alarm_r    <= `SRT_ALARM_RESET;
        end
        else
        begin
            if (wr_mode)
            begin
                if (wstrb_r[0])
                    divisor_r[7:0] <= wdata_r[7:0];
                if (wstrb_r[1])
                    divisor_r[15:8] <= wdata_r[15:8];
                if (wstrb_r[2])
                begin
                    alm_ien_r  <= wdata_r[`SRT_MODE_ALM_IEN];
                    wrap_ien_r <= wdata_r[`SRT_MODE_WRAP_IEN];
                    disable_r  <= wdata_r[`SRT_MODE_DISABLE];
                end
                if (wstrb_r[3])
                    cal_sel_r <= wdata_r[`SRT_MODE_CAL_SEL];
            end
            alarm_r <= alarm_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Status flags, alarm output and interrupt
    // ------------------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wrap_flag_r <= 1'b0;
            alm_flag_r  <= 1'b0;
            irq_d1_r    <= 1'b0;
            irq_d2_r    <= 1'b0;
            irq_o       <= 1'b0;
            alarm_o     <= 1'b0;
        end
        else
        begin
            // A new event in the read cycle wins over the clear
            if (wrap_ev)
                wrap_flag_r <= 1'b1;
            else if (stat_read)
                wrap_flag_r <= 1'b0;
            if (match)
                alm_flag_r <= 1'b1;
            else if (stat_read)
                alm_flag_r <= 1'b0;
            alarm_o <= alm_flag_r;
            // Request level advances one stage per slow clock rising edge
            if (slow_tick)
            begin
                irq_d1_r <= (alm_flag_r & alm_ien_r) | (wrap_flag_r & wrap_ien_r);
                irq_d2_r <= irq_d1_r;
            end
            irq_o <= irq_d2_r & (alm_ien_r | wrap_ien_r);
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r     <= 1'b0;
            awaddr_r      <= 4'h0;
            w_hold_r      <= 1'b0;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SRT_RESP_OKAY;
        end
        else
        begin
            if (aw_fire)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (w_fire)
            begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_do)
            begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `SRT_RESP_OKAY : `SRT_RESP_SLVERR;
            end
            else if (s_axi_bvalid & s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_awready <= ~aw_hold_r & ~aw_fire & ~s_axi_bvalid & ~wr_do;
            s_axi_wready  <= ~w_hold_r & ~w_fire & ~s_axi_bvalid & ~wr_do;
        end
    end

    // ------------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------------
    reg  [31:0] rdata_nxt;

    always @*
    begin
        case ({s_axi_araddr[3:2], 2'h0})
            `SRT_OFS_MODE:
                rdata_nxt = {7'h00, cal_sel_r, 3'h0, disable_r, 2'h0,
                             wrap_ien_r, alm_ien_r, divisor_r};
            `SRT_OFS_ALARM:
                rdata_nxt = alarm_r;
            `SRT_OFS_VALUE:
                rdata_nxt = count_r;
            default:
                rdata_nxt = {30'h0, wrap_flag_r, alm_flag_r};
        endcase
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read channels
    // ------------------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `SRT_RESP_OKAY;
        end
        else
        begin
            if (ar_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `SRT_RESP_OKAY;
                s_axi_rdata <= rdata_nxt;
            end
            else if (s_axi_rvalid & s_axi_rready)
                s_axi_rvalid <= 1'b0;
            s_axi_arready <= ~s_axi_rvalid & ~ar_fire;
        end
    end

endmodule

`default_nettype wire

//--- core/srt_consts.vh
// Constants for the slow-clock real-time timer: register offsets, mode fields,
// reset values and bus answers. Assumes a 32-bit AXI4-Lite register bus.
//
// Behaviour
// - Slow clock divided by a 16-bit prescaler set by the divisor field.
// - Divisor resets to 0x8000, one wrap per second at 32.768 kHz.
// - 32-bit up-counter wraps to zero after its maximum.
// - Every prescaler wrap sets the wrap flag in status.
// - Calendar second select counts external 1 Hz ticks, divisor ignored.
// - Select 0 counts prescaler wraps; wrap flag always follows the prescaler.
// - Interrupt request falls two slow clock cycles after status read.
// - Counter compared with alarm value; equality sets alarm match flag.
// - Alarm register resets to all ones.
// - Alarm match flag always drives the alarm wake output.
// - Status read clears wrap flag and alarm match flag.
// - Restart bit reloads prescaler, restarts it, clears the counter.
// - Timer disable bit stops the prescaler, counter and alarm compare.
`ifndef SRT_CONSTS_VH
`define SRT_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SRT_OFS_MODE        4'h0
`define SRT_OFS_ALARM       4'h4
`define SRT_OFS_VALUE       4'h8
`define SRT_OFS_STATUS      4'hC

// ----------------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------------
`define SRT_MODE_DIV_MSB    15
`define SRT_MODE_ALM_IEN    16
`define SRT_MODE_WRAP_IEN   17
`define SRT_MODE_RESTART    18
`define SRT_MODE_DISABLE    20
`define SRT_MODE_CAL_SEL    24

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define SRT_STAT_ALARM      0
`define SRT_STAT_WRAP       1

// ----------------------------------------------------------------------------
// Reset values and answers
// ----------------------------------------------------------------------------
`define SRT_DIV_RESET       16'h8000
`define SRT_ALARM_RESET     32'hFFFFFFFF
`define SRT_RESP_OKAY       2'h0
`define SRT_RESP_SLVERR     2'h2

`endif

//--- test/srt_timer_properties.sv
// Concurrent checks on the timer's register bus handshakes.
// Assumes the srt_timer port list and a single aclk domain.
`default_nettype none

module srt_props
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq_o,
    input wire logic        alarm_o
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_write_answers: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_answers: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("address taken early");
    a_rresp_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0) else $error("read not okay");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken early");
    a_value_read_only: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 4'h8
        |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == 2'h2)) else $error("value write not refused");
    a_alarm_mirror: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC
        |=> s_axi_rdata[0] == alarm_o) else $error("alarm output differs from match flag");

    c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    c_irq: cover property (irq_o);
    c_alarm: cover property (alarm_o);
endmodule

bind srt_timer srt_props u_props
(
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq_o(irq_o), .alarm_o(alarm_o)
);

`default_nettype wire

//--- test/srt_timer_tb.sv
// Register-level tests of the slow-clock timer over AXI4-Lite.
// Assumes srt_timer; the bench makes the slow clock and the 1 Hz tick itself.
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
$display("[ERR] %0t got %h exp %h", $time, g, e); end end

module srt_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, cal = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    wire         awready, wready, bvalid, arready, rvalid, irq, alarm;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    int          n_fail = 0, check_count = 0;

    always #4 aclk = ~aclk;

    srt_timer DUT
    (
        .aclk(aclk), .aresetn(aresetn), .slow_clk_i(slow), .cal_tick_i(cal),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .irq_o(irq), .alarm_o(alarm)
    );

    // ----------------------------------------------------------------
    // Bus and pin tasks
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw))
        begin
            @(posedge aclk);
            if (!ta && awready === 1'b1)
            begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (!tw && wready === 1'b1)
            begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        `CHK(bresp, er)
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        `CHK(rdata, e)
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Pulses either the slow clock or the calendar tick, pins idle low between
    task automatic tick(input int n, input logic c);
        repeat (n)
        begin
            if (c)
                cal <= 1'b1;
            else
                slow <= 1'b1;
            repeat (4) @(posedge aclk);
            cal <= 1'b0;
            slow <= 1'b0;
            repeat (6) @(posedge aclk);
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        test_done;
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(4'h0, 32'h00008000);
        rd(4'h4, 32'hFFFFFFFF);
        rd(4'h8, 32'h00000000);
        wr(4'h8, 32'h00000001, 2'h2);
        $display("test reset values done");
        wr(4'h0, 32'h00060003, 2'h0);
        tick(6, 1'b0);
        `CHK(irq, 1'b1)
        rd(4'h8, 32'h00000002);
        rd(4'h8, 32'h00000002);
        rd(4'hC, 32'h00000002);
        `CHK(irq, 1'b1)
        tick(2, 1'b0);
        `CHK(irq, 1'b0)
        rd(4'hC, 32'h00000000);
        $display("test prescaler and irq done");
        wr(4'h0, 32'h00000003, 2'h0);
        wr(4'h4, 32'h00000004, 2'h0);
        tick(4, 1'b0);
        `CHK(alarm, 1'b1)
        rd(4'hC, 32'h00000003);
        $display("test alarm done");
        wr(4'h0, 32'h01040003, 2'h0);
        tick(2, 1'b1);
        tick(6, 1'b0);
        rd(4'h8, 32'h00000002);
        rd(4'hC, 32'h00000003);
        wr(4'h0, 32'h00100003, 2'h0);
        tick(6, 1'b0);
        rd(4'h8, 32'h00000002);
        $display("test sources done");
        wr(4'h4, 32'h00000001, 2'h0);
        wr(4'h0, 32'h00050003, 2'h0);
        tick(5, 1'b0);
        `CHK(irq, 1'b1)
        wr(4'h0, 32'h00000003, 2'h0);
        `CHK(irq, 1'b0)
        rd(4'hC, 32'h00000003);
        $display("test alarm interrupt done");
        test_done;
    end
endmodule

`default_nettype wire
